// >>> include/down_timer_pkg.sv
// Purpose: Shared constants and state layout of the down-counting timer, PWM and buzzer
// Assumes: Registers are byte wide in lane 0 of 32-bit Wishbone words; the live count reads back as 10 bits
// Notes on behaviour
// - A 10-bit counter decrements on each tick of the selected, optionally prescaled source.
// - Upper reload bits are written first, low byte second; running timer reloads at underflow.
// - With the timer stopped, writing the low reload byte loads the counter at once.
// - Reading the count register returns the live counter, not the reload buffer.
// - Bit 0 of control A starts or stops counting.
// - Clock-source bit picks the external pin when set, instruction clock when clear.
// - External pin counts on falling edges when edge bit is 1, rising when 0.
// - Prescaler divides when its active-low enable is 0; three-bit ratio field.
// - Software can read the live prescaler count through a read-only register.
// - One-shot mode counts down once to zero and stops after that underflow.
// - Free-running underflow restarts from reload value, or from 0x3FF when reload bit clear.
// - Underflow sets flag bit 3; interrupt requested when its enable and global enable set.
// - Underflow flag stays set until software writes 0; hardware never clears it.
// - PWM enable drives the PWM wave on the shared pin and forces it to output.
// - PWM polarity bit makes the output active low when set, active high when clear.
// - Duty value sets active timer clocks per frame; zero never, 0x3FF for 1023.
// - Upper duty bits written before low duty byte; new duty applied at next underflow, or at once with the timer stopped.
// - Buzzer enable drives the buzzer square wave on the shared pin as output.
// - Buzzer select top bit picks prescaler output at 0, timer output at 1.
// - Codes 0-7 divide prescaler by 2 to 256; codes 8-15 take counter bits 0-7.
// - When PWM and buzzer are both enabled, PWM owns the shared pin.

package down_timer_pkg;

  localparam logic [7:0] TIMER_CONTROL_A_OFS = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_B_OFS = 8'h04;
  localparam logic [7:0] RELOAD_LOW_BYTE_OFS = 8'h08;
  localparam logic [7:0] SHARED_HIGH_BITS_OFS = 8'h0C;
  localparam logic [7:0] PWM_DUTY_LOW_OFS = 8'h10;
  localparam logic [7:0] PRESCALER_COUNT_OFS = 8'h14;
  localparam logic [7:0] BUZZER_CONTROL_OFS = 8'h18;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h1C;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h20;
  localparam logic [7:0] LIVE_COUNT_OFS = 8'h24;

  // Control A fields
  localparam int RUN_BIT = 0;
  localparam int RELOAD_BIT = 1;
  localparam int ONE_SHOT_BIT = 2;
  localparam int ACTIVE_LOW_BIT = 6;
  localparam int PWM_EN_BIT = 7;
  // Control B fields
  localparam int SRC_SEL_BIT = 5;
  localparam int EDGE_SEL_BIT = 4;
  localparam int PRESC_EN_N_BIT = 3;
  // Shared high bits fields
  localparam int RELOAD_HI_LSB = 4;
  localparam int DUTY_HI_LSB = 0;
  // Buzzer, flag and enable fields
  localparam int BUZZ_EN_BIT = 7;
  localparam int BUZZ_SRC_BIT = 3;
  localparam int UNDERFLOW_BIT = 3;
  localparam int GLOBAL_EN_BIT = 7;

  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h08;
  localparam logic [7:0] BUZZ_CTRL_RESET = 8'h0F;
  localparam logic [7:0] PRESC_RESET = 8'hFF;
  localparam logic [9:0] ALL_ONES_COUNT = 10'h3FF;
  localparam logic [9:0] COUNT_RESET = 10'h3FF;

  typedef struct packed {
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] buzzCtrl;
    logic [1:0] reloadHiStage;
    logic [1:0] dutyHiStage;
    logic [9:0] reloadBuf;
    logic [9:0] dutyPend;
    logic [9:0] dutyAct;
    logic [9:0] count;
    logic [7:0] presc;
    logic [7:0] instrDiv;
    logic extPrev;
    logic flag;
    logic flagEn;
    logic globalEn;
    logic wbAck;
    logic [31:0] wbDat;
    logic pinOut;
    logic pinOeN;
    logic irq;
  } state_type;

endpackage

// >>> src/down_timer_pwm_buzzer.sv
// Purpose: 10-bit down timer with prescaler, PWM and buzzer on one shared pin
// Assumes: Classic Wishbone slave, single clock, synchronous external count input
// Notes: Instruction clock is a one-cycle enable from a divider of ref_clk
`timescale 1ns/1ps

module down_timer_pwm_buzzer #(
  parameter int INSTR_DIV = 2
) (
  input wire logic refClk,
  input wire logic rst_n,
  input wire logic [7:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbWeI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire logic externalCountClock,
  output logic sharedOutputPinOut,
  output logic sharedOutputPinOe_n,
  output logic irqReq
);

  down_timer_pkg::state_type st_r;
  down_timer_pkg::state_type st_nxt;

  // ---------------------------------------------------------------
  // Output mapping
  // ---------------------------------------------------------------
  assign wbDatO = st_r.wbDat;
  assign wbAckO = st_r.wbAck;
  assign sharedOutputPinOut = st_r.pinOut;
  assign sharedOutputPinOe_n = st_r.pinOeN;
  assign irqReq = st_r.irq;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic req;
  logic wr;
  logic instrTick;
  logic extTick;
  logic srcTick;
  logic prescTick;
  logic timerTick;
  logic underflow;
  logic running;
  logic [7:0] mask;
  logic [7:0] prescInc;
  logic [2:0] code;
  logic pwmActive;
  logic buzzWave;
  logic [31:0] rdData;
  logic lowReloadWr;
  logic lowDutyWr;
  logic flagWr;

  always_comb
  begin
    st_nxt = st_r;
    req = wbCycI && wbStbI && !st_r.wbAck;
    wr = req && wbWeI && wbSelI[0];
    lowReloadWr = wr && (wbAdrI == down_timer_pkg::RELOAD_LOW_BYTE_OFS);
    lowDutyWr = wr && (wbAdrI == down_timer_pkg::PWM_DUTY_LOW_OFS);
    flagWr = wr && (wbAdrI == down_timer_pkg::IRQ_FLAG_OFS);
    running = st_r.ctrlA[down_timer_pkg::RUN_BIT];

    // Instruction clock enable
    instrTick = (st_r.instrDiv == 8'(INSTR_DIV - 1));
    st_nxt.instrDiv = instrTick ? 8'h00 : 8'(st_r.instrDiv + 8'h01);

    st_nxt.extPrev = externalCountClock;
    extTick = st_r.ctrlB[down_timer_pkg::EDGE_SEL_BIT]
      ? (st_r.extPrev && !externalCountClock)
      : (!st_r.extPrev && externalCountClock);
    srcTick = st_r.ctrlB[down_timer_pkg::SRC_SEL_BIT] ? extTick : instrTick;

    mask = 8'((9'h002 << st_r.ctrlB[2:0]) - 9'h001);
    prescInc = 8'(st_r.presc + 8'h01);
    prescTick = srcTick && ((prescInc & mask) == 8'h00);
    if (srcTick)
    begin
      st_nxt.presc = prescInc;
    end
    timerTick = running && (st_r.ctrlB[down_timer_pkg::PRESC_EN_N_BIT] ? srcTick : prescTick);

    underflow = timerTick && (st_r.count == 10'h000);
    if (timerTick)
    begin
      st_nxt.count = 10'(st_r.count - 10'h001);
    end
    if (underflow)
    begin
      st_nxt.dutyAct = st_r.dutyPend;
      if (st_r.ctrlA[down_timer_pkg::ONE_SHOT_BIT])
      begin
        st_nxt.ctrlA[down_timer_pkg::RUN_BIT] = 1'b0;
        st_nxt.count = st_r.reloadBuf;
      end
      else
      begin
        st_nxt.count = st_r.ctrlA[down_timer_pkg::RELOAD_BIT]
          ? st_r.reloadBuf : down_timer_pkg::ALL_ONES_COUNT;
      end
    end

    // Register writes
    if (wr)
    begin
      unique case (wbAdrI)
        down_timer_pkg::TIMER_CONTROL_A_OFS:
        begin
          st_nxt.ctrlA = wbDatI[7:0];
        end
        down_timer_pkg::TIMER_CONTROL_B_OFS:
        begin
          st_nxt.ctrlB = wbDatI[7:0];
        end
        down_timer_pkg::SHARED_HIGH_BITS_OFS:
        begin
          st_nxt.reloadHiStage = wbDatI[down_timer_pkg::RELOAD_HI_LSB +: 2];
          st_nxt.dutyHiStage = wbDatI[down_timer_pkg::DUTY_HI_LSB +: 2];
        end
        down_timer_pkg::BUZZER_CONTROL_OFS:
        begin
          st_nxt.buzzCtrl = wbDatI[7:0];
        end
        down_timer_pkg::IRQ_ENABLE_OFS:
        begin
          st_nxt.flagEn = wbDatI[down_timer_pkg::UNDERFLOW_BIT];
          st_nxt.globalEn = wbDatI[down_timer_pkg::GLOBAL_EN_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // Low byte commits the staged reload
    if (lowReloadWr)
    begin
      st_nxt.reloadBuf = {st_r.reloadHiStage, wbDatI[7:0]};
      if (!running)
      begin
        st_nxt.count = {st_r.reloadHiStage, wbDatI[7:0]};
      end
    end
    // Low byte commits the staged duty
    if (lowDutyWr)
    begin
      st_nxt.dutyPend = {st_r.dutyHiStage, wbDatI[7:0]};
      if (!running)
      begin
        st_nxt.dutyAct = {st_r.dutyHiStage, wbDatI[7:0]};
      end
    end

    if (flagWr && !wbDatI[down_timer_pkg::UNDERFLOW_BIT])
    begin
      st_nxt.flag = 1'b0;
    end
    if (underflow)
    begin
      st_nxt.flag = 1'b1;
    end
    st_nxt.irq = st_nxt.flag && st_nxt.flagEn && st_nxt.globalEn;

    // Read mux
    rdData = 32'h0000_0000;
    unique case (wbAdrI)
      down_timer_pkg::TIMER_CONTROL_A_OFS: rdData[7:0] = st_r.ctrlA;
      down_timer_pkg::TIMER_CONTROL_B_OFS: rdData[7:0] = st_r.ctrlB;
      down_timer_pkg::RELOAD_LOW_BYTE_OFS: rdData[7:0] = st_r.count[7:0];
      down_timer_pkg::SHARED_HIGH_BITS_OFS:
      begin
        rdData[down_timer_pkg::RELOAD_HI_LSB +: 2] = st_r.count[9:8];
        rdData[down_timer_pkg::DUTY_HI_LSB +: 2] = st_r.dutyHiStage;
      end
      down_timer_pkg::PRESCALER_COUNT_OFS: rdData[7:0] = st_r.presc;
      down_timer_pkg::BUZZER_CONTROL_OFS: rdData[7:0] = st_r.buzzCtrl;
      down_timer_pkg::IRQ_FLAG_OFS: rdData[down_timer_pkg::UNDERFLOW_BIT] = st_r.flag;
      down_timer_pkg::IRQ_ENABLE_OFS:
      begin
        rdData[down_timer_pkg::UNDERFLOW_BIT] = st_r.flagEn;
        rdData[down_timer_pkg::GLOBAL_EN_BIT] = st_r.globalEn;
      end
      down_timer_pkg::LIVE_COUNT_OFS: rdData[9:0] = st_r.count;
      default: rdData = 32'h0000_0000;
    endcase

    // Wishbone answer one cycle after request
    st_nxt.wbAck = req;
    if (req)
    begin
      st_nxt.wbDat = rdData;
    end

    // Active for duty clocks per frame
    pwmActive = st_r.count < st_r.dutyAct;
    code = st_r.buzzCtrl[2:0];
    buzzWave = st_r.buzzCtrl[down_timer_pkg::BUZZ_SRC_BIT] ? st_r.count[code] : st_r.presc[code];

    // PWM first on the shared pin
    if (st_r.ctrlA[down_timer_pkg::PWM_EN_BIT])
    begin
      st_nxt.pinOut = pwmActive ^ st_r.ctrlA[down_timer_pkg::ACTIVE_LOW_BIT];
      st_nxt.pinOeN = 1'b0;
    end
    else if (st_r.buzzCtrl[down_timer_pkg::BUZZ_EN_BIT])
    begin
      st_nxt.pinOut = buzzWave;
      st_nxt.pinOeN = 1'b0;
    end
    else
    begin
      st_nxt.pinOut = 1'b0;
      st_nxt.pinOeN = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge refClk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.ctrlA <= down_timer_pkg::CTRL_A_RESET;
      st_r.ctrlB <= down_timer_pkg::CTRL_B_RESET;
      st_r.buzzCtrl <= down_timer_pkg::BUZZ_CTRL_RESET;
      st_r.presc <= down_timer_pkg::PRESC_RESET;
      st_r.count <= down_timer_pkg::COUNT_RESET;
      st_r.pinOeN <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule // down_timer_pwm_buzzer

// >>> tb/down_timer_pwm_buzzer_assertions.sv
// Purpose: Port-level checks of the timer block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps

module down_timer_pwm_buzzer_assertions #(
  parameter int INSTR_DIV = 2
) (
  input wire logic refClk,
  input wire logic rst_n,
  input wire logic [7:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbWeI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAckO,
  input wire logic externalCountClock,
  input wire logic sharedOutputPinOut,
  input wire logic sharedOutputPinOe_n,
  input wire logic irqReq
);
  logic wrReq;
  assign wrReq = wbCycI && wbStbI && wbWeI;
  default clocking cb @(posedge refClk); endclocking
  default disable iff (!rst_n);
  sequence s_req; wbCycI && wbStbI && !wbAckO; endsequence
  sequence s_ack; wbAckO ##1 !wbAckO; endsequence
  property p_ack_answer; s_req |=> s_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  property p_ack_pulse; wbAckO |=> !wbAckO; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; wbAckO |-> $past(wbCycI && wbStbI); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_idle; !wbCycI |=> !wbAckO; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack while idle");
  property p_ack_cyc; wbAckO |-> wbCycI && wbStbI; endproperty
  a_ack_cyc: assert property (p_ack_cyc) else $error("ack outside cycle");
  property p_dat_hold; $changed(wbDatO) |-> wbAckO; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  property p_irq_clear; $fell(irqReq) |-> $past(wrReq) || $past(wrReq, 2); endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq dropped by itself");
  property p_oe_cause; $changed(sharedOutputPinOe_n) |-> $past(wrReq) || $past(wrReq, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin direction moved");
endmodule // down_timer_pwm_buzzer_assertions

// >>> tb/down_timer_pwm_buzzer_test.sv
// Purpose: Register-driven test of timer, PWM and buzzer
// Assumes: Wishbone classic master tasks
// Notes: Instruction clock is refClk/2
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module down_timer_pwm_buzzer_test;
  localparam logic [7:0] CA = down_timer_pkg::TIMER_CONTROL_A_OFS;
  localparam logic [7:0] CB = down_timer_pkg::TIMER_CONTROL_B_OFS;
  localparam logic [7:0] SH = down_timer_pkg::SHARED_HIGH_BITS_OFS;
  localparam logic [7:0] DL = down_timer_pkg::PWM_DUTY_LOW_OFS;
  localparam logic [7:0] PC = down_timer_pkg::PRESCALER_COUNT_OFS;
  localparam logic [7:0] BZ = down_timer_pkg::BUZZER_CONTROL_OFS;
  localparam logic [7:0] FL = down_timer_pkg::IRQ_FLAG_OFS;
  logic refClk, rst_n, wbWeI, wbCycI, wbStbI, wbAckO, xck, pin, pinOe_n, irqReq, sawHi, sawLo;
  logic [7:0] wbAdrI, p0;
  logic [31:0] wbDatI, wbDatO, rdat;
  logic [3:0] wbSelI;
  logic [9:0] c0, c1;
  int numErrors, checksDone, cycles;
  down_timer_pwm_buzzer #(.INSTR_DIV(2)) DUT (.refClk(refClk), .rst_n(rst_n),
    .wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO), .externalCountClock(xck),
    .sharedOutputPinOut(pin), .sharedOutputPinOe_n(pinOe_n), .irqReq(irqReq));
  always #2 refClk = ~refClk;
  always @(posedge refClk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      numErrors++;
      stopTest();
    end
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge refClk);
    wbAdrI <= a;
    wbWeI <= w;
    wbDatI <= {24'h000000, d};
    wbSelI <= 4'hF;
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    // Watch ack where it is settled, then take the answer at the edge that samples it
    @(negedge refClk);
    while (wbAckO !== 1'b1)
    begin
      @(negedge refClk);
    end
    @(posedge refClk);
    rdat = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d); xfer(a, 1'b1, d); endtask
  task rd(input logic [7:0] a); xfer(a, 1'b0, 8'h00); endtask
  task load(input logic [7:0] h, input logic [7:0] l); wr(SH, h); wr(8'h08, l); endtask
  task cnt(output logic [9:0] c); rd(8'h24); c = rdat[9:0]; endtask
  task lvl(input logic v); @(posedge refClk); xck <= v; repeat (4) @(posedge refClk); endtask
  task waitIrq;
    repeat (200) if (irqReq !== 1'b1) @(posedge refClk);
    `CHK(irqReq, 1'b1)
  endtask
  task sample;
    sawHi = 1'b0;
    sawLo = 1'b0;
    repeat (64)
    begin
      @(posedge refClk);
      if (pin === 1'b1) sawHi = 1'b1;
      if (pin === 1'b0) sawLo = 1'b1;
    end
  endtask
  task stopTest;
    $display("errors=%0d checks=%0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {refClk, rst_n, wbWeI, wbCycI, wbStbI, xck, wbAdrI, wbDatI, wbSelI} = '0;
    repeat (10) @(posedge refClk);
    rst_n <= 1'b1;
    rd(PC); `CHK(rdat[7:0], 8'hFF)
    rd(CB); `CHK(rdat[7:0], 8'h08)
    rd(BZ); `CHK(rdat[7:0], 8'h0F)
    rd(8'h30); `CHK(rdat, 32'h00000000)
    cnt(c0); `CHK(c0, 10'h3FF)
    load(8'h10, 8'h23); cnt(c0); `CHK(c0, 10'h123)
    rd(SH); `CHK(rdat[5:4], 2'b01)
    wr(CA, 8'h03); cnt(c0); cnt(c1); `CHK(c1 < c0, 1'b1)
    load(8'h00, 8'h08); cnt(c0); `CHK(c0 > 10'h100, 1'b1)
    wr(CA, 8'h00); cnt(c0); repeat (20) @(posedge refClk);
    cnt(c1); `CHK(c1, c0)
    load(8'h00, 8'h05); wr(8'h20, 8'h88); wr(CA, 8'h05); waitIrq();
    rd(CA); `CHK(rdat[0], 1'b0)
    cnt(c0); `CHK(c0, 10'h005)
    wr(FL, 8'hFF); rd(FL); `CHK(rdat[3], 1'b1)
    wr(FL, 8'h00); repeat (3) @(posedge refClk);
    `CHK(irqReq, 1'b0)
    load(8'h00, 8'h03); wr(CA, 8'h01); waitIrq();
    cnt(c0); `CHK(c0[9:4], 6'h3F)
    wr(FL, 8'h00); load(8'h00, 8'h40);
    for (int e = 0; e < 2; e++)
    begin
      wr(CB, e ? 8'h38 : 8'h28); cnt(c0); lvl(1'b1);
      cnt(c1); `CHK(c0 - c1, e ? 10'h000 : 10'h001)
      lvl(1'b0); cnt(c0); `CHK(c1 - c0, e ? 10'h001 : 10'h000)
    end
    wr(CB, 8'h21); cnt(c0); rd(PC); p0 = rdat[7:0];
    repeat (8) begin lvl(1'b1); lvl(1'b0); end
    cnt(c1); `CHK(c0 - c1, 10'h002)
    rd(PC); `CHK(rdat[7:0] - p0, 8'h08)
    wr(CA, 8'h00); wr(CB, 8'h08); load(8'h00, 8'h0F); wr(DL, 8'h00);
    wr(CA, 8'h83); sample(); `CHK(pinOe_n, 1'b0)
    `CHK(sawHi, 1'b0)
    wr(CA, 8'hC3); sample(); `CHK(sawLo, 1'b0)
    wr(DL, 8'h0F); sample(); `CHK(sawHi & sawLo, 1'b1)
    wr(CA, 8'h00); repeat (3) @(posedge refClk);
    `CHK(pinOe_n, 1'b1)
    wr(CB, 8'h00); wr(BZ, 8'h80); wr(CA, 8'h01); sample();
    `CHK(pinOe_n, 1'b0)
    `CHK(sawHi & sawLo, 1'b1)
    wr(BZ, 8'h88); sample(); `CHK(sawHi & sawLo, 1'b1)
    wr(CA, 8'h00); wr(DL, 8'h00); wr(CA, 8'hC1); sample(); `CHK(sawLo, 1'b0)
    stopTest();
  end
endmodule // down_timer_pwm_buzzer_test

bind down_timer_pwm_buzzer down_timer_pwm_buzzer_assertions #(.INSTR_DIV(INSTR_DIV)) chk (
  .refClk(refClk), .rst_n(rst_n), .wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI),
  .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO),
  .externalCountClock(externalCountClock), .sharedOutputPinOut(sharedOutputPinOut),
  .sharedOutputPinOe_n(sharedOutputPinOe_n), .irqReq(irqReq));
